// ===== tb/sbc_bus_partner.sv
/*
  far-side bus devices: pull-ups on every pin, pulls on command, scl source.
  assumes the bench sets the command inputs.
*/
`timescale 1ns/100ps
module sbc_bus_partner (
  // pin side
  input wire logic [4:0] i_pin_o,
  input wire logic [4:0] i_pin_oe,
  output logic [4:0] o_level,
  // commands
  input wire logic [4:0] i_pull,
  input wire logic i_scl_run,
  input wire logic i_scl_ch
);
  logic scl_q = 1'b1;
  logic [4:0] scl_low;
  // scl stands high between frames, 80 ns period within
  always #40 scl_q = i_scl_run ? ~scl_q : 1'b1;
  assign scl_low = scl_q ? 5'h00 : (i_scl_ch ? 5'h08 : 5'h02);
  // a released line floats to its pull-up; any low driver wins
  assign o_level = ~((i_pin_oe & ~i_pin_o) | i_pull | scl_low);
endmodule

// ===== tb/sbc_top_bench.sv
/*
  self-checking bench of sbc_top over its register port and pins.
  assumes the checker bound in its own file.
*/
`timescale 1ns/100ps
module sbc_top_bench;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic i_src_clk_req = 1'b0, i_eng_sda = 1'b1, i_eng_scl = 1'b1;
  logic i_sio_so = 1'b1, i_sio_sck = 1'b1, scl_run = 1'b0, scl_ch = 1'b0, ce = 1'b1;
  logic [4:0] i_gpio_out = 5'h1f;
  logic [4:0] i_gpio_oe = 5'h00, pull = 5'h00, lvl, o_gpio_in, o_pin, o_pin_oe;
  logic o_src_clk_en, o_src_tick, o_serial_rst_n, o_mode_sio, o_eng_sda_in, o_eng_scl_in;
  logic o_scl_rise, o_scl_fall, o_sio_si;
  logic [1:0] o_timer_edge_sel;
  int error_cnt = 0, tests_run = 0, cyc = 0, n, m;
  sbc_top #(.SRC_DIV(4), .SRST_CYCLES(4)) i_sbc_top (.i_mclk, .i_rst_n, .i_ce(ce), .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_src_clk_req, .i_eng_sda, .i_eng_scl, .i_sio_so,
    .i_sio_sck, .o_src_clk_en, .o_src_tick, .o_serial_rst_n, .o_mode_sio, .o_eng_sda_in,
    .o_eng_scl_in, .o_scl_rise, .o_scl_fall, .o_sio_si, .o_timer_edge_sel, .i_gpio_out,
    .i_gpio_oe, .o_gpio_in, .i_pin(lvl), .o_pin, .o_pin_oe);
  sbc_bus_partner i_sbc_bus_partner (.i_pin_o(o_pin), .i_pin_oe(o_pin_oe), .o_level(lvl),
    .i_pull(pull), .i_scl_run(scl_run), .i_scl_ch(scl_ch));
  always #5 i_mclk = ~i_mclk;
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // strobe stays up so writes can run back to back; idle or rd drops it
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b0;
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
  endtask
  task automatic idle(input int c);
    repeat (c) begin
      @(posedge i_mclk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
    end
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] m,
    input string nm);
    @(posedge i_mclk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    check(nm, o_rdata & m, exp);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    idle(2);
    rd(12'h027, 8'h00, 8'hff, "switch reset");
    rd(12'hff1, 8'h00, 8'h80, "status reset");
    rd(12'h022, 8'h01, 8'h01, "monitor idle");
    rd(12'h0ab, 8'h00, 8'hff, "unmapped");
    $display("test reset done");
    wr(12'hff1, 8'h80);
    idle(1);
    check("enable no request", o_src_clk_en, 8'h00);
    @(posedge i_mclk) i_src_clk_req <= 1'b1;
    rd(12'hff1, 8'h80, 8'h80, "request flag");
    wr(12'hff1, 8'h80);
    idle(1);
    check("enable on", o_src_clk_en, 8'h01);
    n = 0;
    repeat (16) begin
      @(posedge i_mclk);
      #1;
      n += o_src_tick;
    end
    check("ticks", n, 8'h04);
    wr(12'hff1, 8'h00);
    idle(3);
    check("enable held", o_src_clk_en, 8'h01);
    // a frozen block must not act on the dropped request yet
    @(posedge i_mclk) ce <= 1'b0;
    i_src_clk_req <= 1'b0;
    idle(2);
    check("enable frozen", o_src_clk_en, 8'h01);
    @(posedge i_mclk) ce <= 1'b1;
    idle(2);
    check("enable dropped", o_src_clk_en, 8'h00);
    $display("test source clock done");
    @(posedge i_mclk) i_gpio_oe <= 5'h15;
    idle(2);
    check("plain oe", o_pin_oe, 8'h15);
    @(posedge i_mclk) i_gpio_oe <= 5'h00;
    wr(12'h021, 8'h10);
    wr(12'h027, 8'h00);
    idle(1);
    @(posedge i_mclk) i_eng_sda <= 1'b0;
    idle(8);
    check("ch0 oe", o_pin_oe, 8'h01);
    check("ch0 sink only", o_pin & 5'h03, 8'h00);
    check("ch0 sda in", o_eng_sda_in, 8'h00);
    check("ch0 scl in", o_eng_scl_in, 8'h01);
    check("gpio in", o_gpio_in, 8'h1e);
    wr(12'h027, 8'h41);
    idle(2);
    check("ch1 oe", o_pin_oe, 8'h04);
    check("edge sel", o_timer_edge_sel, 8'h01);
    rd(12'h027, 8'h41, 8'hff, "switch readback");
    @(posedge i_mclk) i_eng_sda <= 1'b1;
    pull <= 5'h04;
    scl_ch <= 1'b1;
    scl_run <= 1'b1;
    n = 0;
    m = 0;
    repeat (40) begin
      @(posedge i_mclk);
      #1;
      n += o_scl_rise;
      m += o_scl_fall;
    end
    @(posedge i_mclk) scl_run <= 1'b0;
    check("ch1 sda in", o_eng_sda_in, 8'h00);
    check("ch1 scl rises", n >= 4, 8'h01);
    check("ch1 scl falls", m >= 4, 8'h01);
    wr(12'h021, 8'h18);
    idle(1);
    @(posedge i_mclk) i_sio_sck <= 1'b0;
    pull <= 5'h08;
    idle(8);
    check("sio mode", o_mode_sio, 8'h01);
    check("sio oe", o_pin_oe, 8'h14);
    check("sio out", o_pin & 5'h14, 8'h04);
    check("sio in", o_sio_si, 8'h00);
    check("sio scl in", o_eng_scl_in, 8'h00);
    @(posedge i_mclk) pull <= 5'h00;
    i_sio_sck <= 1'b1;
    $display("test pins done");
    wr(12'h021, 8'h01);
    wr(12'h021, 8'h02);
    rd(12'h022, 8'h00, 8'h01, "monitor busy");
    check("engine reset", o_serial_rst_n, 8'h00);
    idle(8);
    rd(12'h022, 8'h01, 8'h01, "monitor done");
    wr(12'h021, 8'h01);
    wr(12'h021, 8'h03);
    wr(12'h021, 8'h02);
    idle(3);
    check("disarmed", o_serial_rst_n, 8'h01);
    $display("test soft reset done");
    test_done();
  end
endmodule

// ===== tb/sbc_top_monitor.sv
/*
  port checker of sbc_top.
  assumes one-cycle strobes and a shadow of config writes kept here.
*/
`timescale 1ns/100ps
module sbc_top_monitor (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // register port
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // engine and pins
  input wire logic i_src_clk_req,
  input wire logic i_eng_sda,
  input wire logic o_src_clk_en,
  input wire logic o_src_tick,
  input wire logic o_serial_rst_n,
  input wire logic [4:0] i_gpio_out,
  input wire logic [4:0] i_gpio_oe,
  input wire logic [4:0] o_pin,
  input wire logic [4:0] o_pin_oe
);
  // ------------------------------
  // config shadow
  // ------------------------------
  logic sen_q, sen_d, sio_q, sio_d, chs_q, chs_d, wr21, wrclk;
  assign wr21 = i_ce && i_wr && i_addr == 12'h021;
  assign wrclk = i_ce && i_wr && i_addr == 12'hff1;
  always_comb begin
    sen_d = sen_q;
    sio_d = sio_q;
    chs_d = chs_q;
    if (wr21) begin
      sen_d = i_wdata[4];
      sio_d = i_wdata[3];
    end
    if (i_ce && i_wr && i_addr == 12'h027) begin
      chs_d = i_wdata[6];
    end
  end
  always_ff @(posedge i_mclk) begin
    sen_q <= i_rst_n ? sen_d : 1'b0;
    sio_q <= i_rst_n ? sio_d : 1'b0;
    chs_q <= i_rst_n ? chs_d : 1'b0;
  end
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_req_clears; i_ce && !i_src_clk_req |=> !o_src_clk_en; endproperty
  property p_en_hold; i_ce && i_src_clk_req && o_src_clk_en |=> o_src_clk_en; endproperty
  property p_en_start; i_src_clk_req && wrclk && i_wdata[7] |=> o_src_clk_en; endproperty
  property p_tick_gate; !o_src_clk_en ##1 !o_src_clk_en |-> !o_src_tick; endproperty
  property p_rd_req;
    i_ce && i_rd && i_addr == 12'hff1 |=> o_rdata == {$past(i_src_clk_req), 7'h00};
  endproperty
  property p_rd_idle; i_ce && !i_rd |=> o_rdata == 8'h00; endproperty
  sequence s_srst; wr21 && i_wdata[1:0] == 2'h1 ##1 wr21 && i_wdata[1:0] == 2'h2; endsequence
  property p_srst; s_srst |=> !o_serial_rst_n [*4] ##[1:4] o_serial_rst_n; endproperty
  property p_mon;
    $past(i_rst_n, 2) && i_ce && i_rd && i_addr == 12'h022 && !o_serial_rst_n |=> !o_rdata[0];
  endproperty
  property p_ch0;
    o_serial_rst_n && !i_wr && sen_q && !sio_q && !chs_q
      |=> o_pin_oe[0] == !$past(i_gpio_out[0] && i_eng_sda) && !o_pin[0];
  endproperty
  property p_plain;
    $past(i_rst_n) && !i_wr && !sen_q
      |=> o_pin == $past(i_gpio_out) && o_pin_oe == $past(i_gpio_oe);
  endproperty
  a_req_clears: assert property (p_req_clears) else $error("enable kept without request");
  a_en_hold: assert property (p_en_hold) else $error("enable lost while requested");
  a_en_start: assert property (p_en_start) else $error("enable write ignored");
  a_tick_gate: assert property (p_tick_gate) else $error("tick while stopped");
  a_rd_req: assert property (p_rd_req) else $error("status read wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  a_srst: assert property (p_srst) else $error("soft reset length wrong");
  a_mon: assert property (p_mon) else $error("monitor high in reset");
  a_ch0: assert property (p_ch0) else $error("channel 0 drive wrong");
  a_plain: assert property (p_plain) else $error("plain port drive wrong");
  c_tick: cover property (o_src_clk_en && o_src_tick);
  c_srst: cover property (s_srst);
  c_ch1: cover property (sen_q && chs_q && o_pin_oe[2]);
endmodule
bind sbc_top sbc_top_monitor i_sbc_top_monitor (.i_mclk, .i_rst_n, .i_ce, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_src_clk_req, .i_eng_sda, .o_src_clk_en, .o_src_tick,
  .o_serial_rst_n, .i_gpio_out, .i_gpio_oe, .o_pin, .o_pin_oe);

// ===== verilog/sbc_pin_if.sv
/*
  carrier between the block core and its pin multiplexer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`include "sbc_regs.svh"
interface sbc_pin_if;
  logic serial_en;
  logic mode_sio;
  logic bus_channel_select;
  logic eng_sda;
  logic eng_scl;
  logic sio_so;
  logic sio_sck;
  logic [`SBC_NPIN-1:0] gpio_out;
  logic [`SBC_NPIN-1:0] gpio_oe;
  logic [`SBC_NPIN-1:0] pin_o;
  logic [`SBC_NPIN-1:0] pin_oe;
  modport ctl(output serial_en, mode_sio, bus_channel_select, eng_sda, eng_scl, sio_so, sio_sck,
    gpio_out, gpio_oe, input pin_o, pin_oe);
  modport mux(input serial_en, mode_sio, bus_channel_select, eng_sda, eng_scl, sio_so, sio_sck,
    gpio_out, gpio_oe, output pin_o, pin_oe);
endinterface

// ===== verilog/sbc_pinmux.sv
/*
  registered pin multiplexer: serial interface or plain port per pin.
  assumes the core drives every carrier input on its own clock.
*/
`timescale 1ns/100ps
`include "sbc_regs.svh"
module sbc_pinmux (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // carrier
  sbc_pin_if.mux pif
);
  logic [`SBC_NPIN-1:0] o_d, oe_d, o_q, oe_q;
  logic i2c_sel, sio_sel;

  // ----------------------------------------
  // selection
  // ----------------------------------------
  always_comb begin
    o_d = pif.gpio_out;
    oe_d = pif.gpio_oe;
    i2c_sel = pif.serial_en && !pif.mode_sio;
    sio_sel = pif.serial_en && pif.mode_sio;
    // latch low still pulls: the interface only rules when latches are 1
    if (i2c_sel && !pif.bus_channel_select) begin
      o_d[`SBC_PIN_SDA0] = 1'b0;
      oe_d[`SBC_PIN_SDA0] = !(pif.gpio_out[`SBC_PIN_SDA0] && pif.eng_sda);
      o_d[`SBC_PIN_SCL0] = 1'b0;
      oe_d[`SBC_PIN_SCL0] = !(pif.gpio_out[`SBC_PIN_SCL0] && pif.eng_scl);
    end
    if (i2c_sel && pif.bus_channel_select) begin
      o_d[`SBC_PIN_SDA1] = 1'b0;
      oe_d[`SBC_PIN_SDA1] = !(pif.gpio_out[`SBC_PIN_SDA1] && pif.eng_sda);
      o_d[`SBC_PIN_SCL1] = 1'b0;
      oe_d[`SBC_PIN_SCL1] = !(pif.gpio_out[`SBC_PIN_SCL1] && pif.eng_scl);
    end
    // clocked serial mode lives on the channel 1 group only
    if (sio_sel) begin
      o_d[`SBC_PIN_SDA1] = pif.gpio_out[`SBC_PIN_SDA1] && pif.sio_so;
      oe_d[`SBC_PIN_SDA1] = 1'b1;
      o_d[`SBC_PIN_SCL1] = 1'b0;
      oe_d[`SBC_PIN_SCL1] = 1'b0;
      o_d[`SBC_PIN_SCK1] = pif.gpio_out[`SBC_PIN_SCK1] && pif.sio_sck;
      oe_d[`SBC_PIN_SCK1] = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_q <= '0;
      oe_q <= '0;
    end else if (i_ce) begin
      o_q <= o_d;
      oe_q <= oe_d;
    end
  end

  assign pif.pin_o = o_q;
  assign pif.pin_oe = oe_q;
endmodule

// ===== verilog/sbc_pkg.sv
/*
  types of the serial bus clock/channel/reset block.
  assumes nothing of its surroundings.
*/
package sbc_pkg;
  typedef enum logic {sbc_mode_i2c, sbc_mode_sio} sbc_mode_t;
  typedef enum logic [1:0] {sbc_srst_idle, sbc_srst_armed, sbc_srst_run} sbc_srst_t;
endpackage

// ===== verilog/sbc_regs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  serial bus clock/channel/reset block. assumes inclusion by bare name.
*/
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define SBC_ADDR_W 12
`define SBC_ADDR_PIN_SWITCH 12'h027
`define SBC_ADDR_CLK_SRC 12'hff1
`define SBC_ADDR_CTRL_B 12'h021
`define SBC_ADDR_STAT_A 12'h022

// ----------------------------------------
// fields
// ----------------------------------------
`define SBC_CHS_BIT 6
`define SBC_ES1_BIT 1
`define SBC_ES0_BIT 0
`define SBC_SOURCE_CLOCK_ENABLE_BIT 7
`define SBC_SOURCE_CLOCK_REQUEST_BIT 7
`define SBC_SOFT_RESET_FIELD_LSB 0
`define SBC_MODE_BIT 3
`define SBC_SEN_BIT 4
`define SBC_MON_BIT 0
`define SBC_SOFT_RESET_FIELD_ARM 2'h1
`define SBC_SOFT_RESET_FIELD_FIRE 2'h2

// ----------------------------------------
// pin slots
// ----------------------------------------
`define SBC_NPIN 5
`define SBC_PIN_SDA0 0
`define SBC_PIN_SCL0 1
`define SBC_PIN_SDA1 2
`define SBC_PIN_SCL1 3
`define SBC_PIN_SCK1 4

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SBC_PIN_SWITCH_RST 8'h00
`define SBC_CTRL_B_RST 8'h00
`define SBC_CLK_NS 10
`define SBC_STD_QTR_NS 2500
`define SBC_SRC_DIV (`SBC_STD_QTR_NS / `SBC_CLK_NS)
`define SBC_SRST_CYCLES 4

`endif

// ===== verilog/sbc_sync.sv
/*
  three-flop synchroniser for pin levels; the output moves only once the
  second and third stages agree. assumes inputs asynchronous to i_mclk.
*/
`timescale 1ns/100ps
module sbc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] lvl_d;

  // ----------------------------------------
  // filter
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end

  // idle-high default suits open-drain lines
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      lvl_q <= '1;
    end else if (i_ce) begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;
endmodule

// ===== verilog/sbc_top.sv
/*
  shared infrastructure of the single serial bus channel: source clock
  gating, channel select, pin preparation and software reset.
  assumes a same-clock transfer engine and a one-cycle strobe register port.
*/
// How it works
// - one channel, working as I2C or as clocked 8-bit serial I/O
// - I2C lines go to pin pair 0 or 1 per channel select bit
// - pins not used serially act as ordinary port pins
// - I2C runs standard speed only; no fast or high-speed
// - write-only enable: 1 starts source clock while request is set, 0 has no effect
// - request at 0 clears the enable, stopping the source clock
// - request flag readable at bit 7 of clock status
// - writing 01 then 10 to reset field resets the interface
// - monitor bit 0 reads 0 while software reset runs
`timescale 1ns/100ps
`include "sbc_regs.svh"
module sbc_top
  import sbc_pkg::*;
#(
  parameter int SRC_DIV = `SBC_SRC_DIV,
  parameter int SRST_CYCLES = `SBC_SRST_CYCLES
) (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // register port
  input wire logic [`SBC_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // transfer engine side
  input wire logic i_src_clk_req,
  input wire logic i_eng_sda,
  input wire logic i_eng_scl,
  input wire logic i_sio_so,
  input wire logic i_sio_sck,
  output logic o_src_clk_en,
  output logic o_src_tick,
  output logic o_serial_rst_n,
  output logic o_mode_sio,
  output logic o_eng_sda_in,
  output logic o_eng_scl_in,
  output logic o_scl_rise,
  output logic o_scl_fall,
  output logic o_sio_si,
  output logic [1:0] o_timer_edge_sel,
  // port latch side
  input wire logic [`SBC_NPIN-1:0] i_gpio_out,
  input wire logic [`SBC_NPIN-1:0] i_gpio_oe,
  output logic [`SBC_NPIN-1:0] o_gpio_in,
  // pins
  input wire logic [`SBC_NPIN-1:0] i_pin,
  output logic [`SBC_NPIN-1:0] o_pin,
  output logic [`SBC_NPIN-1:0] o_pin_oe
);
  localparam int DW = $clog2(SRC_DIV + 1);
  localparam int RW = $clog2(SRST_CYCLES + 1);

  sbc_pin_if pif ();
  logic [`SBC_NPIN-1:0] pin_s;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic wr_sw, wr_clk, wr_cb, rd_hit;
  always_comb begin
    wr_sw = i_wr && (i_addr == `SBC_ADDR_PIN_SWITCH);
    wr_clk = i_wr && (i_addr == `SBC_ADDR_CLK_SRC);
    wr_cb = i_wr && (i_addr == `SBC_ADDR_CTRL_B);
    rd_hit = i_rd;
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic chs_q, chs_d;
  logic [1:0] es_q, es_d;
  sbc_mode_t mode_q, mode_d;
  logic sen_q, sen_d;
  always_comb begin
    chs_d = chs_q;
    es_d = es_q;
    mode_d = mode_q;
    sen_d = sen_q;
    if (wr_sw) begin
      chs_d = i_wdata[`SBC_CHS_BIT];
      es_d = {i_wdata[`SBC_ES1_BIT], i_wdata[`SBC_ES0_BIT]};
    end
    if (wr_cb) begin
      mode_d = i_wdata[`SBC_MODE_BIT] ? sbc_mode_sio : sbc_mode_i2c;
      sen_d = i_wdata[`SBC_SEN_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      chs_q <= 1'(`SBC_PIN_SWITCH_RST >> `SBC_CHS_BIT);
      es_q <= 2'h0;
      mode_q <= sbc_mode_i2c;
      sen_q <= 1'b0;
    end else if (i_ce) begin
      chs_q <= chs_d;
      es_q <= es_d;
      mode_q <= mode_d;
      sen_q <= sen_d;
    end
  end

  // ----------------------------------------
  // source clock enable
  // ----------------------------------------
  logic source_clock_enable_q, source_clock_enable_d;
  always_comb begin
    source_clock_enable_d = source_clock_enable_q;
    if (wr_clk) begin
      if (i_wdata[`SBC_SOURCE_CLOCK_ENABLE_BIT]) begin
        source_clock_enable_d = 1'b1;
      end else if (!(i_src_clk_req && source_clock_enable_q)) begin
        source_clock_enable_d = 1'b0;
      end
    end
    // a dropped request wins over any write
    if (!i_src_clk_req) begin
      source_clock_enable_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      source_clock_enable_q <= 1'b0;
    end else if (i_ce) begin
      source_clock_enable_q <= source_clock_enable_d;
    end
  end

  // ----------------------------------------
  // software reset sequence
  // ----------------------------------------
  sbc_srst_t srst_q, srst_d;
  logic [RW-1:0] rcnt_q, rcnt_d;
  logic [1:0] swf;
  always_comb begin
    srst_d = srst_q;
    rcnt_d = rcnt_q;
    swf = i_wdata[`SBC_SOFT_RESET_FIELD_LSB +: 2];
    unique case (srst_q)
      sbc_srst_idle: begin
        if (wr_cb && swf == `SBC_SOFT_RESET_FIELD_ARM) begin
          srst_d = sbc_srst_armed;
        end
      end
      sbc_srst_armed: begin
        if (wr_cb && swf == `SBC_SOFT_RESET_FIELD_FIRE) begin
          srst_d = sbc_srst_run;
          rcnt_d = RW'(SRST_CYCLES - 1);
        end else if (wr_cb && swf != `SBC_SOFT_RESET_FIELD_ARM) begin
          srst_d = sbc_srst_idle;
        end
      end
      sbc_srst_run: begin
        if (rcnt_q == '0) begin
          srst_d = sbc_srst_idle;
        end else begin
          rcnt_d = rcnt_q - RW'(1);
        end
      end
      default: srst_d = sbc_srst_idle;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      srst_q <= sbc_srst_idle;
      rcnt_q <= '0;
    end else if (i_ce) begin
      srst_q <= srst_d;
      rcnt_q <= rcnt_d;
    end
  end

  logic srst_run;
  assign srst_run = (srst_q == sbc_srst_run) || (srst_d == sbc_srst_run);

  // ----------------------------------------
  // standard-speed source tick
  // ----------------------------------------
  // the divider is fixed, so software cannot select a faster bus rate
  logic [DW-1:0] div_q, div_d;
  logic tick_q, tick_d;
  always_comb begin
    div_d = div_q;
    tick_d = 1'b0;
    if (!source_clock_enable_q || srst_run) begin
      div_d = '0;
    end else if (div_q == DW'(SRC_DIV - 1)) begin
      div_d = '0;
      tick_d = 1'b1;
    end else begin
      div_d = div_q + DW'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (i_ce) begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------
  // pin sampling and link edges
  // ----------------------------------------
  sbc_sync #(.W(`SBC_NPIN)) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async(i_pin),
    .o_level(pin_s)
  );

  logic scl_sel, sda_sel;
  logic scl_prev_q, rise_q, fall_q, sda_in_q, scl_in_q, si_q, mon_q, srst_n_q;
  logic scl_prev_d, rise_d, fall_d, sda_in_d, scl_in_d, si_d, mon_d, srst_n_d;
  logic [7:0] rdata_q, rdata_d;
  logic [`SBC_NPIN-1:0] gin_q;
  always_comb begin
    scl_sel = chs_q ? pin_s[`SBC_PIN_SCL1] : pin_s[`SBC_PIN_SCL0];
    sda_sel = chs_q ? pin_s[`SBC_PIN_SDA1] : pin_s[`SBC_PIN_SDA0];
    scl_prev_d = scl_sel;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (sen_q && mode_q == sbc_mode_i2c && !srst_run) begin
      rise_d = scl_sel && !scl_prev_q;
      fall_d = !scl_sel && scl_prev_q;
    end
    sda_in_d = sda_sel;
    scl_in_d = scl_sel;
    si_d = pin_s[`SBC_PIN_SCL1];
    mon_d = !srst_run;
    srst_n_d = !srst_run;
    rdata_d = 8'h00;
    if (rd_hit) begin
      unique case (i_addr)
        `SBC_ADDR_PIN_SWITCH: begin
          rdata_d[`SBC_CHS_BIT] = chs_q;
          rdata_d[`SBC_ES1_BIT] = es_q[1];
          rdata_d[`SBC_ES0_BIT] = es_q[0];
        end
        `SBC_ADDR_CLK_SRC: rdata_d[`SBC_SOURCE_CLOCK_REQUEST_BIT] = i_src_clk_req;
        `SBC_ADDR_CTRL_B: begin
          rdata_d[`SBC_MODE_BIT] = (mode_q == sbc_mode_sio);
          rdata_d[`SBC_SEN_BIT] = sen_q;
        end
        `SBC_ADDR_STAT_A: rdata_d[`SBC_MON_BIT] = mon_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      scl_prev_q <= 1'b1;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      sda_in_q <= 1'b1;
      scl_in_q <= 1'b1;
      si_q <= 1'b1;
      mon_q <= 1'b1;
      srst_n_q <= 1'b0;
      rdata_q <= 8'h00;
      gin_q <= '1;
    end else if (i_ce) begin
      scl_prev_q <= scl_prev_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      sda_in_q <= sda_in_d;
      scl_in_q <= scl_in_d;
      si_q <= si_d;
      mon_q <= mon_d;
      srst_n_q <= srst_n_d;
      rdata_q <= rdata_d;
      gin_q <= pin_s;
    end
  end

  // ----------------------------------------
  // pin multiplexer
  // ----------------------------------------
  assign pif.serial_en = sen_q;
  assign pif.mode_sio = (mode_q == sbc_mode_sio);
  assign pif.bus_channel_select = chs_q;
  assign pif.eng_sda = i_eng_sda || srst_run;
  assign pif.eng_scl = i_eng_scl || srst_run;
  assign pif.sio_so = i_sio_so;
  assign pif.sio_sck = i_sio_sck;
  assign pif.gpio_out = i_gpio_out;
  assign pif.gpio_oe = i_gpio_oe;

  sbc_pinmux u_mux (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .pif(pif.mux)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_rdata = rdata_q;
  assign o_src_clk_en = source_clock_enable_q;
  assign o_src_tick = tick_q;
  assign o_serial_rst_n = srst_n_q;
  assign o_mode_sio = (mode_q == sbc_mode_sio);
  assign o_eng_sda_in = sda_in_q;
  assign o_eng_scl_in = scl_in_q;
  assign o_scl_rise = rise_q;
  assign o_scl_fall = fall_q;
  assign o_sio_si = si_q;
  assign o_timer_edge_sel = es_q;
  assign o_gpio_in = gin_q;
  assign o_pin = pif.pin_o;
  assign o_pin_oe = pif.pin_oe;
endmodule
